// ### sim/tb_fpu_state_frame_save.sv
`timescale 1ns/1ns
`include "fpu_frame_params.svh"
// compares a value with its expectation and counts the result
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got %0h exp %0h", $time, (g), (e)); end end
module tb_fpu_state_frame_save;
  logic CLOCK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, rd;
  logic PREADY, PSLVERR, EXC_REPORT, INEX_TAKEN, FRAME_DONE, IRQ, err;
  logic INSTR_VALID = 0, INSTR_COND = 0, SAVE_REQ = 0, RESTORE_NULL = 0;
  logic PIPE_BUSY = 0, CU_EXC = 0, CU_UNIMP = 0, CU_UNSUP = 0, CU_POST = 0;
  logic CU_PACKED = 0, CU_SHORT_DN = 0, WB_OVERFLOW_FLAG = 0, WB_UNFL = 0, WB_INEX = 0;
  logic [15:0] CU_CMD = 0, WB_CMD = 0;
  logic [31:0] CU_PC = 0, CU_IADDR = 0;
  logic [95:0] PACKED_OP = 96'h1111_2222_3333_4444_5555_6666;
  fpu_frame_pkg::ext_op_t SRC_OP = '{1'b0, 15'h3fff, 64'h8000_0000_0000_0000};
  fpu_frame_pkg::ext_op_t DST_OP = '0;
  fpu_frame_pkg::wb_op_t WB_OP = '0;
  fpu_frame_pkg::frame_kind_t FRAME_KIND;
  logic [5:0] FRAME_WORDS;
  int mismatches = 0, n_checks = 0, n_rep = 0, n_inex = 0;
  always #5 CLOCK = ~CLOCK;
  // counts one-cycle pulses from the unit
  always @(posedge CLOCK) begin
    n_rep <= n_rep + int'(EXC_REPORT === 1'b1);
    n_inex <= n_inex + int'(INEX_TAKEN === 1'b1);
  end
  fpu_state_frame_save u_dut (
    .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .INSTR_VALID(INSTR_VALID),
    .INSTR_COND(INSTR_COND), .SAVE_REQ(SAVE_REQ),
    .RESTORE_NULL(RESTORE_NULL), .PIPE_BUSY(PIPE_BUSY), .CU_EXC(CU_EXC),
    .CU_UNIMP(CU_UNIMP), .CU_UNSUP(CU_UNSUP), .CU_POST(CU_POST),
    .CU_PACKED(CU_PACKED), .CU_SHORT_DN(CU_SHORT_DN), .CU_CMD(CU_CMD),
    .CU_PC(CU_PC), .CU_IADDR(CU_IADDR), .SRC_OP(SRC_OP), .DST_OP(DST_OP),
    .PACKED_OP(PACKED_OP), .WB_OVERFLOW_FLAG(WB_OVERFLOW_FLAG), .WB_UNFL(WB_UNFL),
    .WB_INEX(WB_INEX), .WB_CMD(WB_CMD), .WB_OP(WB_OP),
    .EXC_REPORT(EXC_REPORT), .INEX_TAKEN(INEX_TAKEN),
    .FRAME_DONE(FRAME_DONE), .FRAME_KIND(FRAME_KIND),
    .FRAME_WORDS(FRAME_WORDS), .IRQ(IRQ)
  );
  // selectors of the strobe inputs
  localparam int sel_instr = 0, sel_save = 1, sel_restore = 2;
  localparam int sel_cu_exc = 3, sel_cu_unimp = 4, sel_cu_unsup = 5;
  localparam int sel_wb_overflow_flag = 6;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge CLOCK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1;
    for (i = 0; i < 16 && PREADY !== 1'b1; i++) @(posedge CLOCK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    if (i == 16) begin mismatches++; end_of_test(); end
  endtask
  // drives the strobe input picked by sel
  task automatic strobe(input int sel, input logic v);
    case (sel)
      sel_instr:    INSTR_VALID <= v;
      sel_save:     SAVE_REQ <= v;
      sel_restore:  RESTORE_NULL <= v;
      sel_cu_exc:   CU_EXC <= v;
      sel_cu_unimp: CU_UNIMP <= v;
      sel_cu_unsup: CU_UNSUP <= v;
      default:      WB_OVERFLOW_FLAG <= v;
    endcase
  endtask
  // one-cycle strobe, then two idle cycles
  task automatic pulse(input int sel);
    @(posedge CLOCK);
    strobe(sel, 1'b1);
    @(posedge CLOCK);
    strobe(sel, 1'b0);
    repeat (2) @(posedge CLOCK);
  endtask
  // waits for the frame decision and checks kind and size
  task automatic frame(input fpu_frame_pkg::frame_kind_t k, input int w);
    int i;
    for (i = 0; i < 40 && FRAME_DONE !== 1'b1; i++) @(negedge CLOCK);
    if (i == 40) begin mismatches++; end_of_test(); end
    `CHK(FRAME_KIND, k)
    `CHK(FRAME_WORDS, 6'(w))
    @(posedge CLOCK);
  endtask
  task automatic save(input fpu_frame_pkg::frame_kind_t k, input int w);
    pulse(sel_save);
    frame(k, w);
  endtask
  initial begin
    repeat (12) @(posedge CLOCK);
    RST <= 0;
    INSTR_COND <= 1;
    pulse(sel_instr);
    save(fpu_frame_pkg::FRAME_NULL, 0);
    INSTR_COND <= 0;
    pulse(sel_instr);
    save(fpu_frame_pkg::FRAME_IDLE, 0);
    $display("null and idle test done");
    apb(1, `OFS_CTRL, 32'h0000_0002);
    WB_CMD <= 16'h0004;
    WB_OP <= '{1'b1, 16'h4000, 67'h4_0000_0000_0000_0003, 1'b1};
    pulse(sel_wb_overflow_flag);
    `CHK(n_inex, 1)
    apb(0, `OFS_EXC_BYTES, 0);
    `CHK(rd[15:0], 16'h4810)
    apb(0, `OFS_FRAME_INFO, 0);
    `CHK(rd[17:10], 8'h01)
    apb(0, `OFS_WB_TEMP, 0);
    `CHK(rd, 32'h0000_0003)
    apb(0, `OFS_WB_TEMP + 8'h08, 0);
    `CHK(rd, 32'ha000_6000)
    save(fpu_frame_pkg::FRAME_BUSY, 50);
    apb(0, `OFS_FRAME_INFO, 0);
    `CHK(rd[17:10], 8'hc8)
    apb(1, `OFS_IRQ_MASK, 32'h0000_000f);
    repeat (2) @(posedge CLOCK);
    `CHK(IRQ, 1'b1)
    apb(1, `OFS_IRQ_STAT, 32'h0000_000f);
    apb(0, `OFS_IRQ_STAT, 0);
    `CHK(rd, 32'h0000_0000)
    `CHK(IRQ, 1'b0)
    apb(0, `OFS_IRQ_MASK, 0);
    `CHK(rd, 32'h0000_000f)
    apb(0, 8'hfc, 0);
    `CHK({err, rd}, 33'h1_0000_0000)
    $display("overflow and interrupt test done");
    CU_CMD <= 16'h0004;
    CU_PC <= 32'h1234_5678;
    CU_IADDR <= 32'h0000_1000;
    CU_SHORT_DN <= 1;
    pulse(sel_cu_unimp);
    save(fpu_frame_pkg::FRAME_UNIMP, 26);
    apb(0, `OFS_CMD_WORDS, 0);
    `CHK(rd[15:0], 16'h0005)
    `CHK(rd[31:16], 16'h0021)
    apb(0, `OFS_FRAME_INFO, 0);
    `CHK(rd[11:0], 12'h00d)
    apb(0, `OFS_CU_PC, 0);
    `CHK(rd, 32'h1234_5678)
    apb(0, `OFS_CU_IADDR, 0);
    `CHK(rd, 32'h0000_1000)
    $display("unimplemented test done");
    CU_CMD <= 16'h4022;
    CU_PACKED <= 1;
    CU_POST <= 1;
    pulse(sel_cu_unsup);
    `CHK(n_rep, 3)
    pulse(sel_instr);
    `CHK(n_rep, 4)
    save(fpu_frame_pkg::FRAME_BUSY, 50);
    apb(0, `OFS_FRAME_INFO, 0);
    `CHK(rd[11:6], 6'h0a)
    apb(0, `OFS_SRC_TEMP, 0);
    `CHK(rd, 32'h5555_6666)
    apb(0, `OFS_SRC_TEMP + 8'h04, 0);
    `CHK(rd, 32'h3333_4444)
    apb(0, `OFS_DST_TEMP, 0);
    `CHK(rd, 32'h1111_2222)
    $display("unsupported test done");
    CU_POST <= 0;
    PIPE_BUSY <= 1;
    pulse(sel_save);
    pulse(sel_cu_exc);
    PIPE_BUSY <= 0;
    frame(fpu_frame_pkg::FRAME_BUSY, 50);
    `CHK(n_rep, 4)
    pulse(sel_restore);
    save(fpu_frame_pkg::FRAME_NULL, 0);
    $display("wait and restore test done");
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge CLOCK);
    mismatches++;
    end_of_test();
  end
endmodule // tb_fpu_state_frame_save

// ### src/fpu_frame_params.svh
`ifndef FPU_FRAME_PARAMS_SVH
`define FPU_FRAME_PARAMS_SVH
// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CTRL        8'h00
`define OFS_IRQ_STAT    8'h04
`define OFS_IRQ_MASK    8'h08
`define OFS_FRAME_INFO  8'h0c
`define OFS_CMD_WORDS   8'h10
`define OFS_CU_PC       8'h14
`define OFS_CU_IADDR    8'h18
`define OFS_EXC_BYTES   8'h1c
`define OFS_SRC_TEMP    8'h20
`define OFS_DST_TEMP    8'h2c
`define OFS_WB_TEMP     8'h38
// ****************************************************************
// reset values and frame sizes
// ****************************************************************
`define CTRL_RESET      8'h00
`define WORDS_UNIMP     6'h1a
`define WORDS_BUSY      6'h32
// ****************************************************************
// exception byte bit positions (current / accrued)
// ****************************************************************
`define EXC_OVERFLOW_FLAG        4
`define EXC_UNFL        3
`define EXC_ROUND_INEXACT       1
`define ACC_OVERFLOW_FLAG        6
`define ACC_UNFL        5
`define ACC_INEX        3
// ****************************************************************
// interrupt status bit positions
// ****************************************************************
`define IRQ_FRAME       0
`define IRQ_REPORT      1
`define IRQ_INEX        2
`define IRQ_WB          3
// ****************************************************************
// command word codes
// ****************************************************************
`define OP_SQRT         7'h04
`define OP_SQRT_MAP     7'h05
`define OP_SQRT_ENC     7'h21
`define OP_ADD          7'h22
`define OP_SUB          7'h28
`define OP_MUL          7'h23
`define OP_DIV          7'h20
`define CLASS_RR        3'h0
`define CLASS_MR        3'h2
`define CLASS_MOVE_OUT  3'h3
// ****************************************************************
// operand tags
// ****************************************************************
`define TAG_NORM        3'h0
`define TAG_ZERO        3'h1
`define TAG_INF         3'h2
`define TAG_NAN         3'h3
`define TAG_EXT_DN      3'h4
`define TAG_SD_DN       3'h5
`endif

// ### src/fpu_frame_pkg.sv
package fpu_frame_pkg;
  // extended precision operand
  typedef struct packed {
    logic        sign;
    logic [14:0] exp;
    logic [63:0] mant;
  } ext_op_t;
  // internal-format intermediate result
  typedef struct packed {
    logic        sign;
    logic [15:0] exp;
    logic [66:0] mant;
    logic        sticky_bit;
  } wb_op_t;
  typedef enum logic [1:0] {
    FRAME_NULL  = 2'h0,
    FRAME_IDLE  = 2'h1,
    FRAME_UNIMP = 2'h2,
    FRAME_BUSY  = 2'h3
  } frame_kind_t;
  typedef enum logic [1:0] {
    S_RUN  = 2'h0,
    S_WAIT = 2'h1,
    S_EMIT = 2'h3
  } save_state_t;
endpackage

// ### src/fpu_state_frame_save.sv
`timescale 1ns/1ns
`include "fpu_frame_params.svh"
// Notes on behaviour
// [RULE_01] overflow, overflow disabled, inexact enabled: take inexact, set flags
// [RULE_02] pending exception: any fp instruction except state save reports again
// [RULE_03] state save waits for pipeline; exceptions then recorded, not reported
// [RULE_04] state save yields exactly one of busy, null, idle, unimplemented
// [RULE_05] last instruction unimplemented gives a 26-word frame
// [RULE_06] pending unsupported data type gives a 50-word busy frame
// [RULE_07] null frames after reset or null restore until nonconditional op
// [RULE_08] idle frame when nothing pending and a nonconditional op has run
// [RULE_09] first command word copied, square root low seven bits 4 become 5
// [RULE_10] encoded command word for write-back faults, square root is 21 hex
// [RULE_11] conversion flag set on any conversion fault; unimp frame means packed
// [RULE_12] write-back flag only for overflow_flag/unfl/inexact arithmetic, class 0 or 2
// [RULE_13] source temporary extended; packed keeps bits 63..0 in mantissa
// [RULE_14] destination temporary extended; packed keeps bits 95..64 low mantissa
// [RULE_15] operation class is bits 15..13 of the first command word
// [RULE_16] tags: norm 0, zero 1, inf 2, nan 3, ext denorm 4, short denorm 5
// [RULE_17] post-instruction flag only for class 3 move-out faults
// [RULE_18] write-back temporary holds internal result with overflow and sticky
// [RULE_19] conversion stage pc and instruction address are captured
module fpu_state_frame_save (
  input  wire logic                  CLOCK,
  input  wire logic                  RST,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [7:0]            PADDR,
  input  wire logic [31:0]           PWDATA,
  output logic      [31:0]           PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  input  wire logic                  INSTR_VALID,
  input  wire logic                  INSTR_COND,
  input  wire logic                  SAVE_REQ,
  input  wire logic                  RESTORE_NULL,
  input  wire logic                  PIPE_BUSY,
  input  wire logic                  CU_EXC,
  input  wire logic                  CU_UNIMP,
  input  wire logic                  CU_UNSUP,
  input  wire logic                  CU_POST,
  input  wire logic                  CU_PACKED,
  input  wire logic                  CU_SHORT_DN,
  input  wire logic [15:0]           CU_CMD,
  input  wire logic [31:0]           CU_PC,
  input  wire logic [31:0]           CU_IADDR,
  input  wire fpu_frame_pkg::ext_op_t SRC_OP,
  input  wire fpu_frame_pkg::ext_op_t DST_OP,
  input  wire logic [95:0]           PACKED_OP,
  input  wire logic                  WB_OVERFLOW_FLAG,
  input  wire logic                  WB_UNFL,
  input  wire logic                  WB_INEX,
  input  wire logic [15:0]           WB_CMD,
  input  wire fpu_frame_pkg::wb_op_t WB_OP,
  output logic                       EXC_REPORT,
  output logic                       INEX_TAKEN,
  output logic                       FRAME_DONE,
  output fpu_frame_pkg::frame_kind_t FRAME_KIND,
  output logic      [5:0]            FRAME_WORDS,
  output logic                       IRQ
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  // tag of an extended operand
  function automatic logic [2:0] op_tag(input fpu_frame_pkg::ext_op_t op,
                                        input logic short_dn);
    if (short_dn)
      op_tag = `TAG_SD_DN;
    else if (op.exp == 15'h7fff)
      op_tag = (op.mant[62:0] == 63'h0) ? `TAG_INF : `TAG_NAN;
    else if (op.exp == 15'h0 && op.mant == 64'h0)
      op_tag = `TAG_ZERO;
    else
      op_tag = (op.exp == 15'h0 || !op.mant[63]) ? `TAG_EXT_DN : `TAG_NORM;
  endfunction
  // square root remap of the low seven command bits
  function automatic logic [15:0] remap_cmd(input logic [15:0] cmd);
    if (cmd[6:0] == `OP_SQRT)
      remap_cmd = {cmd[15:7], `OP_SQRT_MAP};
    else
      remap_cmd = cmd;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  fpu_frame_pkg::save_state_t state;
  fpu_frame_pkg::save_state_t next_state;
  logic [7:0]  ctrl;
  logic [3:0]  irq_stat;
  logic [3:0]  irq_mask;
  logic [7:0]  cur_exc;
  logic [7:0]  acc_exc;
  logic        initialized;
  logic        pending;
  logic        last_unimp;
  logic [15:0] first_cmd;
  logic [15:0] enc_cmd;
  logic [31:0] conv_pc;
  logic [31:0] conv_iaddr;
  logic        conv_flag;
  logic        wb_flag;
  logic        post_flag;
  logic [2:0]  src_tag;
  logic [2:0]  dst_tag;
  fpu_frame_pkg::ext_op_t src_tmp;
  fpu_frame_pkg::ext_op_t dst_tmp;
  fpu_frame_pkg::wb_op_t  wb_tmp;

  // ****************************************************************
  // event decode
  // ****************************************************************
  wire        in_run     = (state == fpu_frame_pkg::S_RUN);
  wire        cu_evt     = CU_EXC | CU_UNIMP | CU_UNSUP;
  wire [2:0]  wb_class   = WB_CMD[15:13];
  wire [6:0]  wb_op      = WB_CMD[6:0];
  wire        wb_arith   = (wb_op == `OP_ADD) | (wb_op == `OP_SUB) |
                           (wb_op == `OP_MUL) | (wb_op == `OP_DIV) |
                           (wb_op == `OP_SQRT);
  wire        wb_legal   = wb_arith & ((wb_class == `CLASS_RR) |
                                       (wb_class == `CLASS_MR));
  wire        wb_evt     = (WB_OVERFLOW_FLAG | WB_UNFL | WB_INEX) & wb_legal; // [RULE_12]
  wire        en_overflow_flag    = ctrl[`EXC_OVERFLOW_FLAG];
  wire        en_unfl    = ctrl[`EXC_UNFL];
  wire        en_inex    = ctrl[`EXC_ROUND_INEXACT];
  wire        overflow_flag_inex  = wb_evt & WB_OVERFLOW_FLAG & ~en_overflow_flag & en_inex; // [RULE_01]
  wire        wb_trap    = wb_evt & ((WB_OVERFLOW_FLAG & en_overflow_flag) |
                           (WB_UNFL & en_unfl) | (WB_INEX & en_inex) |
                           overflow_flag_inex);
  wire        new_exc    = cu_evt | wb_trap;
  wire        noncond    = INSTR_VALID & ~INSTR_COND; // [RULE_07]
  wire        save_ready = ~PIPE_BUSY | pending | new_exc; // [RULE_03]
  wire [15:0] cu_cmd1    = remap_cmd(CU_CMD); // [RULE_09]
  wire [15:0] wb_cmd1    = remap_cmd(WB_CMD);
  wire [2:0]  opclass    = first_cmd[15:13]; // [RULE_15]

  // next kind of frame, one of four by priority
  wire fpu_frame_pkg::frame_kind_t next_kind =
    last_unimp  ? fpu_frame_pkg::FRAME_UNIMP : // [RULE_05]
    pending     ? fpu_frame_pkg::FRAME_BUSY  : // [RULE_06]
    initialized ? fpu_frame_pkg::FRAME_IDLE  : // [RULE_08]
                  fpu_frame_pkg::FRAME_NULL;   // [RULE_04] [RULE_07]
  wire [5:0] next_words =
    (next_kind == fpu_frame_pkg::FRAME_UNIMP) ? `WORDS_UNIMP :
    (next_kind == fpu_frame_pkg::FRAME_BUSY)  ? `WORDS_BUSY  : 6'h00;

  // reports only while running, never while a save drains
  wire next_report = in_run & (new_exc | (INSTR_VALID & pending)); // [RULE_02]

  // ****************************************************************
  // save sequencer
  // ****************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      fpu_frame_pkg::S_RUN:  if (SAVE_REQ) next_state = fpu_frame_pkg::S_WAIT;
      fpu_frame_pkg::S_WAIT: if (save_ready) next_state = fpu_frame_pkg::S_EMIT;
      fpu_frame_pkg::S_EMIT: next_state = fpu_frame_pkg::S_RUN;
      default:               next_state = fpu_frame_pkg::S_RUN;
    endcase
  end

  // state register and frame result outputs
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state       <= fpu_frame_pkg::S_RUN;
      FRAME_DONE  <= 1'b0;
      FRAME_KIND  <= fpu_frame_pkg::FRAME_NULL;
      FRAME_WORDS <= 6'h00;
      EXC_REPORT  <= 1'b0;
      INEX_TAKEN  <= 1'b0;
    end else begin
      state      <= next_state;
      FRAME_DONE <= (state == fpu_frame_pkg::S_EMIT);
      EXC_REPORT <= next_report;
      INEX_TAKEN <= overflow_flag_inex & in_run; // [RULE_01]
      if (state == fpu_frame_pkg::S_EMIT) begin
        FRAME_KIND  <= next_kind;
        FRAME_WORDS <= next_words;
      end
    end
  end

  // null/idle flag, pending and last-unimplemented tracking
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      initialized <= 1'b0;
      pending     <= 1'b0;
      last_unimp  <= 1'b0;
    end else begin
      if (RESTORE_NULL)
        initialized <= 1'b0;
      else if (noncond)
        initialized <= 1'b1; // [RULE_07]
      if (new_exc)
        pending <= 1'b1; // [RULE_03]
      else if (RESTORE_NULL || state == fpu_frame_pkg::S_EMIT)
        pending <= 1'b0;
      if (CU_UNIMP)
        last_unimp <= 1'b1;
      else if (noncond || RESTORE_NULL || state == fpu_frame_pkg::S_EMIT)
        last_unimp <= 1'b0;
    end
  end

  // ****************************************************************
  // frame field capture
  // ****************************************************************
  // conversion stage fields
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      first_cmd  <= 16'h0000;
      conv_pc    <= 32'h0000_0000;
      conv_iaddr <= 32'h0000_0000;
      conv_flag  <= 1'b0;
      post_flag  <= 1'b0;
      src_tag    <= `TAG_NORM;
      dst_tag    <= `TAG_NORM;
      src_tmp    <= '0;
      dst_tmp    <= '0;
    end else if (cu_evt) begin
      first_cmd  <= cu_cmd1; // [RULE_09]
      conv_pc    <= CU_PC; // [RULE_19]
      conv_iaddr <= CU_IADDR; // [RULE_19]
      conv_flag  <= CU_UNIMP ? CU_PACKED : 1'b1; // [RULE_11]
      post_flag  <= CU_POST & (CU_CMD[15:13] == `CLASS_MOVE_OUT); // [RULE_17]
      src_tag    <= op_tag(SRC_OP, CU_SHORT_DN); // [RULE_16]
      dst_tag    <= op_tag(DST_OP, 1'b0); // [RULE_16]
      if (CU_PACKED) begin
        src_tmp <= '{sign: 1'b0, exp: 15'h0, mant: PACKED_OP[63:0]}; // [RULE_13]
        dst_tmp <= '{sign: 1'b0, exp: 15'h0,
                     mant: {32'h0000_0000, PACKED_OP[95:64]}}; // [RULE_14]
      end else begin
        src_tmp <= SRC_OP; // [RULE_13]
        dst_tmp <= DST_OP; // [RULE_14]
      end
    end
  end

  // write-back stage fields
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      enc_cmd <= 16'h0000;
      wb_flag <= 1'b0;
      wb_tmp  <= '0;
    end else if (wb_evt) begin
      enc_cmd <= (wb_op == `OP_SQRT) ? {wb_cmd1[15:7], `OP_SQRT_ENC}
                                     : wb_cmd1; // [RULE_10]
      wb_flag <= 1'b1; // [RULE_12]
      wb_tmp  <= WB_OP; // [RULE_18]
    end else if (state == fpu_frame_pkg::S_EMIT || RESTORE_NULL) begin
      wb_flag <= 1'b0;
    end
  end

  // exception bytes
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      cur_exc <= 8'h00;
      acc_exc <= 8'h00;
    end else if (wb_evt) begin
      cur_exc <= 8'h00;
      cur_exc[`EXC_OVERFLOW_FLAG]  <= WB_OVERFLOW_FLAG; // [RULE_01]
      cur_exc[`EXC_UNFL]  <= WB_UNFL;
      cur_exc[`EXC_ROUND_INEXACT] <= WB_INEX;
      acc_exc[`ACC_OVERFLOW_FLAG]  <= acc_exc[`ACC_OVERFLOW_FLAG] | WB_OVERFLOW_FLAG; // [RULE_01]
      acc_exc[`ACC_UNFL]  <= acc_exc[`ACC_UNFL] | WB_UNFL;
      acc_exc[`ACC_INEX]  <= acc_exc[`ACC_INEX] | WB_INEX | overflow_flag_inex;
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  wire        acc_ph   = PSEL & PENABLE & ~PREADY;
  wire        wr_en    = PSEL & PENABLE & PREADY & PWRITE;
  wire [3:0]  irq_evt  = {wb_evt, overflow_flag_inex, next_report,
                          (state == fpu_frame_pkg::S_EMIT)};
  wire [3:0]  w1c      = (wr_en && PADDR == `OFS_IRQ_STAT) ? PWDATA[3:0]
                                                           : 4'h0;
  wire [31:0] frame_info = {14'h0, FRAME_WORDS, post_flag, wb_flag,
                            conv_flag, opclass, dst_tag, src_tag};
  wire        hit =
    (PADDR[1:0] == 2'b00) && (PADDR <= (`OFS_WB_TEMP + 8'h08));
  // read selection
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (PADDR)
      `OFS_CTRL:               rd_mux = {24'h0, ctrl};
      `OFS_IRQ_STAT:           rd_mux = {28'h0, irq_stat};
      `OFS_IRQ_MASK:           rd_mux = {28'h0, irq_mask};
      `OFS_FRAME_INFO:         rd_mux = frame_info;
      `OFS_CMD_WORDS:          rd_mux = {enc_cmd, first_cmd};
      `OFS_CU_PC:              rd_mux = conv_pc;
      `OFS_CU_IADDR:           rd_mux = conv_iaddr;
      `OFS_EXC_BYTES:          rd_mux = {16'h0, acc_exc, cur_exc};
      `OFS_SRC_TEMP:           rd_mux = src_tmp.mant[31:0];
      `OFS_SRC_TEMP + 8'h04:   rd_mux = src_tmp.mant[63:32];
      `OFS_SRC_TEMP + 8'h08:   rd_mux = {src_tmp.sign, src_tmp.exp, 16'h0};
      `OFS_DST_TEMP:           rd_mux = dst_tmp.mant[31:0];
      `OFS_DST_TEMP + 8'h04:   rd_mux = dst_tmp.mant[63:32];
      `OFS_DST_TEMP + 8'h08:   rd_mux = {dst_tmp.sign, dst_tmp.exp, 16'h0};
      `OFS_WB_TEMP:            rd_mux = wb_tmp.mant[31:0];
      `OFS_WB_TEMP + 8'h04:    rd_mux = wb_tmp.mant[63:32];
      `OFS_WB_TEMP + 8'h08:    rd_mux = {wb_tmp.sign, wb_tmp.exp,
                                         wb_tmp.sticky_bit,
                                         wb_tmp.mant[66:64], 11'h0};
      default:                 rd_mux = 32'h0000_0000;
    endcase
  end

  // bus answer, one wait state, unmapped gives an error
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= acc_ph;
      PSLVERR <= acc_ph & ~hit;
      PRDATA  <= (acc_ph & ~PWRITE & hit) ? rd_mux : 32'h0000_0000;
    end
  end

  // writable registers; sticky set wins over clear
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ctrl     <= `CTRL_RESET;
      irq_mask <= 4'h0;
      irq_stat <= 4'h0;
      IRQ      <= 1'b0;
    end else begin
      if (wr_en && PADDR == `OFS_CTRL)
        ctrl <= PWDATA[7:0];
      if (wr_en && PADDR == `OFS_IRQ_MASK)
        irq_mask <= PWDATA[3:0];
      irq_stat <= (irq_stat & ~w1c) | irq_evt;
      IRQ      <= |(((irq_stat & ~w1c) | irq_evt) & irq_mask);
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  a_overflow_flag_inex_take: assert property ( // [RULE_01]
    (overflow_flag_inex && in_run) |=> INEX_TAKEN && cur_exc[`EXC_OVERFLOW_FLAG]
      && acc_exc[`ACC_OVERFLOW_FLAG] && acc_exc[`ACC_INEX])
    else $error("overflow with inexact enabled not taken as inexact");
  a_pending_report: assert property ( // [RULE_02]
    (in_run && INSTR_VALID && pending) |=> EXC_REPORT)
    else $error("instruction during pending exception not reported");
  a_wait_silent: assert property ( // [RULE_03]
    (state == fpu_frame_pkg::S_WAIT) |=> !EXC_REPORT)
    else $error("exception reported while a save drains");
  a_done_after_emit: assert property ( // [RULE_04]
    FRAME_DONE |-> $past(state) == fpu_frame_pkg::S_EMIT && !$past(FRAME_DONE))
    else $error("frame emitted without a save");
  a_unimp_size: assert property ( // [RULE_05]
    (state == fpu_frame_pkg::S_EMIT && last_unimp) |=>
      FRAME_KIND == fpu_frame_pkg::FRAME_UNIMP && FRAME_WORDS == 6'h1a)
    else $error("unimplemented frame wrong");
  a_busy_size: assert property ( // [RULE_06]
    (state == fpu_frame_pkg::S_EMIT && pending && !last_unimp) |=>
      FRAME_KIND == fpu_frame_pkg::FRAME_BUSY && FRAME_WORDS == 6'h32)
    else $error("busy frame wrong");
  a_cond_keeps_null: assert property ( // [RULE_07]
    (INSTR_VALID && INSTR_COND && !initialized) |=> !initialized)
    else $error("conditional instruction left null state");
  a_idle_frame: assert property ( // [RULE_08]
    (state == fpu_frame_pkg::S_EMIT && !pending && !last_unimp
      && initialized) |=> FRAME_KIND == fpu_frame_pkg::FRAME_IDLE)
    else $error("idle frame not emitted");
  a_sqrt_remap: assert property ( // [RULE_09]
    (cu_evt && CU_CMD[6:0] == `OP_SQRT) |=> first_cmd[6:0] == `OP_SQRT_MAP)
    else $error("square root command not remapped");
  a_wb_flag_class: assert property ( // [RULE_12]
    $rose(wb_flag) |-> $past(wb_legal))
    else $error("write-back flag set for illegal operation");
  a_post_class: assert property ( // [RULE_17]
    post_flag |-> opclass == `CLASS_MOVE_OUT)
    else $error("post flag outside class 3");

  c_null_frame: cover property (
    FRAME_DONE && FRAME_KIND == fpu_frame_pkg::FRAME_NULL);
  c_idle_frame: cover property (
    FRAME_DONE && FRAME_KIND == fpu_frame_pkg::FRAME_IDLE);
  c_unimp_frame: cover property (
    FRAME_DONE && FRAME_KIND == fpu_frame_pkg::FRAME_UNIMP);
  c_busy_frame: cover property (
    FRAME_DONE && FRAME_KIND == fpu_frame_pkg::FRAME_BUSY);
  c_overflow_flag_inex: cover property (INEX_TAKEN);
endmodule // fpu_state_frame_save
